/* File: hw/civ_map.vh */
/*
  Register map, field positions, vectors and reset values of the
  interrupt vectoring block. Assumes inclusion by bare name, once or more.
*/
`ifndef CIV_MAP_VH
`define CIV_MAP_VH
`define CIV_ADDR_W 12
`define CIV_OFF_STATUS 12'h01C
`define CIV_OFF_PREQ1 12'h040
`define CIV_OFF_PEN1 12'h044
`define CIV_OFF_PREQ2 12'h048
`define CIV_OFF_PEN2 12'h04C
`define CIV_OFF_CPU 12'h050
`define CIV_OFF_VEC 12'h054
`define CIV_STATUS_RST 8'h00
`define CIV_PREG_RST 8'h00
`define CIV_PEN2_MASK 8'hEF
`define CIV_B_PEND 7
`define CIV_B_TCLKF 6
`define CIV_B_T0F 5
`define CIV_B_EXTF 4
`define CIV_B_PGEN 3
`define CIV_B_TCLKE 2
`define CIV_B_T0E 1
`define CIV_B_EXTE 0
`define CIV_VEC_RESET 16'h0000
`define CIV_VEC_EXT 16'h0008
`define CIV_VEC_T0 16'h0010
`define CIV_VEC_TCLK 16'h0018
`define CIV_VEC_PERIPH 16'h0020
`define CIV_NPSRC 15
`endif

/* File: hw/civ_edge_sync.v */
/*
  Pin edge detector: three flip-flop synchroniser plus selectable edge.
  Assumes pin_i is asynchronous to sys_clk_i.
*/
module civ_edge_sync (
  input wire sys_clk_i,
  input wire reset_i,
  input wire pin_i,
  input wire rise_sel_i,
  output wire edge_o
);
  reg s1;
  reg s2;
  reg s3;
  reg lvl;

  // Plain three-stage shift; the level register below carries the reset
  always @(posedge sys_clk_i) begin
    s1 <= pin_i;
    s2 <= s1;
    s3 <= s2;
  end

  // Level follows the pin during reset, so a pin idling high gives no false edge
  always @(posedge sys_clk_i) begin
    if (reset_i)
      lvl <= s3;
    else if (s2 == s3)
      lvl <= s3;
  end

  // Edge seen when agreed level differs from the held one
  assign edge_o = (s2 == s3) && (s3 != lvl) && (s3 == rise_sel_i);
endmodule

/* File: hw/civ_apb_slave.v */
/*
  APB slave front end: zero wait state, decodes enables into write and read strobes.
  Assumes a standard APB master on sys_clk_i.
*/
module civ_apb_slave (
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  output wire wr_o,
  output wire rd_o,
  output wire pready_o
);
  // No wait states: every access completes in its first access cycle
  assign pready_o = 1'b1;
  assign wr_o = psel_i & penable_i & pwrite_i;
  assign rd_o = psel_i & penable_i & ~pwrite_i;
endmodule

/* File: hw/civ_core_irq.v */
/*
  Interrupt collection and vectoring for an 8-bit core.
  Assumes the sequencer asserts instr_boundary_i at each instruction start,
  pushes the stack on take_o and pops it on return_from_irq_instr_i.
*/
`include "civ_map.vh"
module civ_core_irq (
  input wire sys_clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire ext_irq_pin_i,
  input wire timer_clock_pin_i,
  input wire ext_rise_sel_i,
  input wire tclk_rise_sel_i,
  input wire timer_zero_ovf_i,
  input wire [14:0] periph_event_i,
  input wire instr_boundary_i,
  input wire return_from_irq_instr_i,
  output wire take_o,
  output reg [15:0] vector_o,
  output wire global_irq_disable_o
);
  // Status register fields
  reg tclk_pin_edge_flag;
  reg timer_zero_ovf_flag;
  reg ext_pin_edge_flag;
  reg periph_group_enable;
  reg tclk_pin_edge_enable;
  reg timer_zero_ovf_enable;
  reg ext_pin_edge_enable;
  reg global_irq_disable;
  wire [7:0] periph_request_reg_one;
  reg [7:0] periph_enable_reg_one;
  wire [7:0] periph_request_reg_two;
  reg [7:0] periph_enable_reg_two;
  wire [14:0] p_flag;
  wire [14:0] p_wr_data;
  wire [14:0] p_wr_hit;
  wire wr_preq1;
  wire wr_preq2;
  reg [15:0] next_vector;
  reg hazard_take;
  wire wr;
  wire ext_edge;
  wire tclk_edge;
  wire [14:0] p_req;
  wire [14:0] p_en;
  wire periph_pending_flag;
  wire ext_req;
  wire t0_req;
  wire tclk_req;
  wire per_req;
  wire any_req;
  wire st_wr;
  wire en_drop;
  wire [7:0] status_rd;

  // Bus front end; no read strobe is needed since reads are captured early
  civ_apb_slave u_apb (
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .wr_o(wr),
    .rd_o(),
    .pready_o(pready_o)
  );

  // Both pins pass the same three-stage synchroniser
  civ_edge_sync u_ext (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .pin_i(ext_irq_pin_i),
    .rise_sel_i(ext_rise_sel_i),
    .edge_o(ext_edge)
  );

  civ_edge_sync u_tclk (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .pin_i(timer_clock_pin_i),
    .rise_sel_i(tclk_rise_sel_i),
    .edge_o(tclk_edge)
  );

  // Unmapped addresses answer with an error, writes there are dropped
  // Stray writes must never alias onto the status register
  assign pslverr_o = psel_i & penable_i &
    !(paddr_i == `CIV_OFF_STATUS || paddr_i == `CIV_OFF_PREQ1 ||
      paddr_i == `CIV_OFF_PEN1 || paddr_i == `CIV_OFF_PREQ2 ||
      paddr_i == `CIV_OFF_PEN2 || paddr_i == `CIV_OFF_CPU ||
      paddr_i == `CIV_OFF_VEC);

  // Fifteen peripheral flags, the reserved bit 4 of group two is skipped
  // Flat source order: group one bits first, then group two
  assign p_req = {periph_request_reg_two[7:5], periph_request_reg_two[3:0],
                  periph_request_reg_one};
  assign p_en = {periph_enable_reg_two[7:5], periph_enable_reg_two[3:0],
                 periph_enable_reg_one};
  assign periph_pending_flag = |(p_req & p_en);

  // Request qualification per source
  // Each enable gates only its own flag; the flags themselves never wait
  assign ext_req = ext_pin_edge_flag & ext_pin_edge_enable;
  assign t0_req = timer_zero_ovf_flag & timer_zero_ovf_enable;
  assign tclk_req = tclk_pin_edge_flag & tclk_pin_edge_enable;
  assign per_req = periph_pending_flag & periph_group_enable;
  assign any_req = ext_req | t0_req | tclk_req | per_req;

  // Taken only at an instruction boundary, which sets the latency
  // A pin event landing inside a two-cycle instruction waits for the
  // next boundary, so the extra cycle of latency needs no logic of its own
  assign take_o = instr_boundary_i & ~global_irq_disable &
    (any_req | hazard_take);
  assign global_irq_disable_o = global_irq_disable;

  // Write to status that drops an enable whose flag is set
  // Only a bus write can clear an enable, so no other path needs watching
  assign st_wr = wr & (paddr_i == `CIV_OFF_STATUS);
  assign en_drop = st_wr & ~global_irq_disable & (
    (ext_pin_edge_flag & ext_pin_edge_enable & ~pwdata_i[`CIV_B_EXTE]) |
    (timer_zero_ovf_flag & timer_zero_ovf_enable & ~pwdata_i[`CIV_B_T0E]) |
    (tclk_pin_edge_flag & tclk_pin_edge_enable & ~pwdata_i[`CIV_B_TCLKE]) |
    (periph_pending_flag & periph_group_enable & ~pwdata_i[`CIV_B_PGEN]));

  // Fixed priority vector choice
  // The hazard overrides every source and clears no flag
  always @* begin
    if (hazard_take)
      next_vector = `CIV_VEC_RESET;
    else if (ext_req)
      next_vector = `CIV_VEC_EXT;
    else if (t0_req)
      next_vector = `CIV_VEC_T0;
    else if (tclk_req)
      next_vector = `CIV_VEC_TCLK;
    else
      next_vector = `CIV_VEC_PERIPH;
  end

  // Hazard latch, held until the next take, which then goes to reset address
  // A new drop wins over a take in the same cycle, so it is never lost
  // Limitation: only bus writes are seen, software must mask first to avoid it
  always @(posedge sys_clk_i) begin
    if (reset_i)
      hazard_take <= 1'b0;
    else if (en_drop)
      hazard_take <= 1'b1;
    else if (take_o)
      hazard_take <= 1'b0;
  end

  // Core status bit: set on take, cleared on return, writable by software
  // Reset leaves interrupts disabled until software opens them
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      global_irq_disable <= 1'b1;
      vector_o <= `CIV_VEC_RESET;
    end else begin
      if (take_o) begin
        global_irq_disable <= 1'b1;
        vector_o <= next_vector;
      end else if (return_from_irq_instr_i)
        global_irq_disable <= 1'b0;
      else if (wr && paddr_i == `CIV_OFF_CPU)
        global_irq_disable <= pwdata_i[0];
    end
  end

  // Status register: set beats both software and vectoring clears
  // Writing one to a flag sets it, which lets software raise a test request
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      {tclk_pin_edge_flag, timer_zero_ovf_flag, ext_pin_edge_flag} <= 3'h0;
      {periph_group_enable, tclk_pin_edge_enable} <= 2'h0;
      {timer_zero_ovf_enable, ext_pin_edge_enable} <= 2'h0;
    end else begin
      if (st_wr) begin
        tclk_pin_edge_flag <= pwdata_i[`CIV_B_TCLKF];
        timer_zero_ovf_flag <= pwdata_i[`CIV_B_T0F];
        ext_pin_edge_flag <= pwdata_i[`CIV_B_EXTF];
        periph_group_enable <= pwdata_i[`CIV_B_PGEN];
        tclk_pin_edge_enable <= pwdata_i[`CIV_B_TCLKE];
        timer_zero_ovf_enable <= pwdata_i[`CIV_B_T0E];
        ext_pin_edge_enable <= pwdata_i[`CIV_B_EXTE];
      end
      if (take_o && !hazard_take) begin
        if (next_vector == `CIV_VEC_EXT)
          ext_pin_edge_flag <= 1'b0;
        if (next_vector == `CIV_VEC_T0)
          timer_zero_ovf_flag <= 1'b0;
        if (next_vector == `CIV_VEC_TCLK)
          tclk_pin_edge_flag <= 1'b0;
      end
      if (ext_edge)
        ext_pin_edge_flag <= 1'b1;
      if (timer_zero_ovf_i)
        timer_zero_ovf_flag <= 1'b1;
      if (tclk_edge)
        tclk_pin_edge_flag <= 1'b1;
    end
  end

  // Bus strobes for the two request groups
  assign wr_preq1 = wr & (paddr_i == `CIV_OFF_PREQ1);
  assign wr_preq2 = wr & (paddr_i == `CIV_OFF_PREQ2);

  // Write data and strobes in flat source order, bit 4 of group two skipped
  assign p_wr_data = {pwdata_i[7:5], pwdata_i[3:0], pwdata_i[7:0]};
  assign p_wr_hit = {{7{wr_preq2}}, {8{wr_preq1}}};

  // One cell per peripheral source; no vectoring path reaches these cells
  genvar gi;
  generate
    for (gi = 0; gi < `CIV_NPSRC; gi = gi + 1) begin : g_pflag
      reg flag;
      always @(posedge sys_clk_i) begin
        if (reset_i)
          flag <= 1'b0;
        else if (periph_event_i[gi])
          flag <= 1'b1;
        else if (p_wr_hit[gi])
          flag <= p_wr_data[gi]; // relies on this software clear
      end
      assign p_flag[gi] = flag;
    end
  endgenerate

  // Request groups as software sees them; the missing bit reads zero
  assign periph_request_reg_one = p_flag[7:0];
  assign periph_request_reg_two = {p_flag[14:12], 1'b0, p_flag[11:8]};

  // Enables are plain software registers
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      periph_enable_reg_one <= `CIV_PREG_RST;
      periph_enable_reg_two <= `CIV_PREG_RST;
    end else begin
      if (wr && paddr_i == `CIV_OFF_PEN1)
        periph_enable_reg_one <= pwdata_i[7:0];
      if (wr && paddr_i == `CIV_OFF_PEN2)
        periph_enable_reg_two <= pwdata_i[7:0] & `CIV_PEN2_MASK;
    end
  end

  assign status_rd = {periph_pending_flag, tclk_pin_edge_flag, timer_zero_ovf_flag,
                      ext_pin_edge_flag, periph_group_enable, tclk_pin_edge_enable,
                      timer_zero_ovf_enable, ext_pin_edge_enable};

  // Registered read data, captured in the setup cycle
  // Capturing early keeps the read path off the access-phase decode
  always @(posedge sys_clk_i) begin
    if (reset_i)
      prdata_o <= 32'h00000000;
    else if (psel_i && !penable_i && !pwrite_i) begin
      if (paddr_i == `CIV_OFF_STATUS)
        prdata_o <= {24'h000000, status_rd};
      else if (paddr_i == `CIV_OFF_PREQ1)
        prdata_o <= {24'h000000, periph_request_reg_one};
      else if (paddr_i == `CIV_OFF_PEN1)
        prdata_o <= {24'h000000, periph_enable_reg_one};
      else if (paddr_i == `CIV_OFF_PREQ2)
        prdata_o <= {24'h000000, periph_request_reg_two};
      else if (paddr_i == `CIV_OFF_PEN2)
        prdata_o <= {24'h000000, periph_enable_reg_two};
      else if (paddr_i == `CIV_OFF_CPU)
        prdata_o <= {31'h00000000, global_irq_disable};
      else if (paddr_i == `CIV_OFF_VEC)
        prdata_o <= {16'h0000, vector_o};
      else
        prdata_o <= 32'h00000000;
    end
  end
endmodule

/* File: dv/civ_core_irq_properties.sv */
/* Checker for the interrupt vectoring block, bound to its top module.
   Assumes one clock domain and a synchronous active-high reset. */
module civ_irq_chk (
  input logic sys_clk_i,
  input logic reset_i,
  input logic psel_i,
  input logic penable_i,
  input logic pwrite_i,
  input logic pready_o,
  input logic instr_boundary_i,
  input logic return_from_irq_instr_i,
  input logic take_o,
  input logic [15:0] vector_o,
  input logic global_irq_disable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // A take is a pulse followed by the disable bit standing high
  sequence s_take;
    take_o ##1 global_irq_disable_o;
  endsequence
  a_take_gated: assert property (take_o |-> !global_irq_disable_o && instr_boundary_i)
    else $error("take while disabled or off boundary");
  a_take_masks: assert property (take_o |-> s_take)
    else $error("disable not set after take");
  a_take_single: assert property (take_o |=> !take_o)
    else $error("take longer than one cycle");
  a_vector_legal: assert property (take_o |=>
    vector_o inside {16'h0000, 16'h0008, 16'h0010, 16'h0018, 16'h0020})
    else $error("vector outside the fixed set");
  a_vector_held: assert property (!take_o |=> $stable(vector_o))
    else $error("vector moved without a take");
  a_return_clears: assert property (return_from_irq_instr_i && !take_o |=>
    !global_irq_disable_o)
    else $error("return did not clear disable");
  a_disable_holds: assert property (global_irq_disable_o && !return_from_irq_instr_i &&
    !(psel_i && penable_i && pwrite_i) |=> global_irq_disable_o)
    else $error("disable dropped on its own");
  a_apb_no_wait: assert property (psel_i && penable_i |-> pready_o)
    else $error("access phase without ready");
endmodule
bind civ_core_irq civ_irq_chk civ_irq_chk_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o),
  .instr_boundary_i(instr_boundary_i), .return_from_irq_instr_i(return_from_irq_instr_i),
  .take_o(take_o), .vector_o(vector_o), .global_irq_disable_o(global_irq_disable_o));

/* File: dv/civ_seq_model.sv */
/* Behavioural core sequencer: instruction starts, stack and return.
   Assumes the block answers take within the boundary cycle. */
module civ_seq_model (
  input logic sys_clk_i,
  input logic reset_i,
  input logic run_i,
  input logic [3:0] gap_i,
  input logic ret_req_i,
  input logic take_i,
  output logic boundary_o,
  output logic ret_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  int depth;
  // Gap sets prompt or slow instruction pacing; run low freezes starts
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      cnt <= 0;
      depth <= 0;
      boundary_o <= 1'b0;
      ret_o <= 1'b0;
    end else begin
      boundary_o <= run_i && cnt == 0;
      cnt <= (cnt == 0) ? gap_i : cnt - 1;
      ret_o <= run_i && cnt == 0 && ret_req_i && depth > 0;
      // Push on take, pop on return; the return address itself is not modelled
      depth <= depth + (take_i ? 1 : 0) - (ret_o ? 1 : 0);
    end
  end
endmodule

/* File: dv/tb.sv */
/* Self-checking bench for the interrupt vectoring block over APB.
   Assumes the map header and a sequencer model beside the block. */
`include "civ_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ext_pin = 0, tclk_pin = 1;
  logic ext_sel = 1, tclk_sel = 0, t0_ovf = 0, run = 1, ret_req = 0;
  logic pready, pslverr, bnd, ret, take, gdis, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [14:0] pev = 0;
  logic [15:0] vec;
  logic [3:0] gap = 1;
  int error_cnt = 0, checks_done = 0;
  civ_core_irq civ_core_irq_inst (.sys_clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ext_irq_pin_i(ext_pin),
    .timer_clock_pin_i(tclk_pin), .ext_rise_sel_i(ext_sel), .tclk_rise_sel_i(tclk_sel),
    .timer_zero_ovf_i(t0_ovf), .periph_event_i(pev), .instr_boundary_i(bnd),
    .return_from_irq_instr_i(ret), .take_o(take), .vector_o(vec), .global_irq_disable_o(gdis));
  civ_seq_model civ_seq_model_inst (.sys_clk_i(clk), .reset_i(rst), .run_i(run), .gap_i(gap),
    .ret_req_i(ret_req), .take_i(take), .boundary_o(bnd), .ret_o(ret));
  initial forever #25 clk = ~clk;
  task results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge only
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin error_cnt++; results(); end
    rd = prdata; err = pslverr;
    psel <= 0; pen <= 0;
  endtask
  // Waits a bounded time for a take, then compares the vector
  task take_wait(input logic [15:0] v);
    int n;
    #1;
    for (n = 0; n < 200 && take !== 1'b1; n++) begin @(posedge clk); #1; end
    if (n == 200) begin error_cnt++; results(); end
    @(posedge clk); #1;
    check("vector", vec, v);
  endtask
  task ret_irq;
    int n;
    ret_req <= 1;
    for (n = 0; n < 200 && gdis !== 1'b0; n++) begin @(posedge clk); #1; end
    if (n == 200) begin error_cnt++; results(); end
    ret_req <= 0;
  endtask
  // Pins pass a synchroniser, so allow settle cycles after each edge
  task pin_edge(input bit ext);
    if (ext) ext_pin <= ~ext_pin; else tclk_pin <= ~tclk_pin;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    apb(0, `CIV_OFF_STATUS, 0); check("status rst", rd, 32'h0);
    apb(0, `CIV_OFF_CPU, 0); check("disable rst", rd, 32'h1);
    apb(1, `CIV_OFF_STATUS, 32'hFF); apb(0, `CIV_OFF_STATUS, 0); check("status rw", rd, 32'h7F);
    apb(1, `CIV_OFF_STATUS, 32'h0);
    apb(0, 12'h000, 0); check("unmapped err", {err, rd[30:0]}, 32'h80000000);
    $display("test registers done");
    // Flags must rise with every enable off and interrupts disabled
    @(posedge clk); t0_ovf <= 1; pev <= 15'h7FFF;
    @(posedge clk); t0_ovf <= 0; pev <= 0;
    pin_edge(1); pin_edge(0);
    apb(0, `CIV_OFF_STATUS, 0); check("flags", rd, 32'h70);
    apb(0, `CIV_OFF_PREQ1, 0); check("req one", rd, 32'hFF);
    apb(0, `CIV_OFF_PREQ2, 0); check("req two", rd, 32'hEF);
    $display("test flags done");
    // Flag bits are written as ones so the pending flags survive the enable write
    apb(1, `CIV_OFF_STATUS, 32'h7F); apb(1, `CIV_OFF_PEN1, 32'h01);
    apb(1, `CIV_OFF_CPU, 0); take_wait(`CIV_VEC_EXT);
    apb(0, `CIV_OFF_STATUS, 0); check("after ext", rd, 32'hEF);
    ret_irq(); take_wait(`CIV_VEC_T0);
    ret_irq(); take_wait(`CIV_VEC_TCLK);
    gap <= 5;
    ret_irq(); take_wait(`CIV_VEC_PERIPH);
    apb(0, `CIV_OFF_PREQ1, 0); check("periph kept", rd, 32'hFF);
    apb(1, `CIV_OFF_PREQ1, 0); apb(1, `CIV_OFF_PREQ2, 0);
    apb(0, `CIV_OFF_STATUS, 0); check("all served", rd, 32'h0F);
    ret_irq();
    $display("test vectors done");
    // Freeze instruction starts so the enable clear meets a live flag
    run <= 0; ext_sel <= 0;
    apb(1, `CIV_OFF_STATUS, 32'h01); pin_edge(1);
    apb(1, `CIV_OFF_STATUS, 32'h00);
    run <= 1; take_wait(`CIV_VEC_RESET);
    ret_irq();
    $display("test hazard done");
    results();
  end
endmodule
